/* inc/ctsc_pkg.sv */
// Package for the CPU turbo speed controller
package ctsc_pkg;
   localparam logic [15:0] IO_BASE        = 16'hD000;
   localparam logic [15:0] IO_LAST        = 16'hDFFF;
   localparam logic [15:0] FAST_RW_LO     = 16'hD0A0;
   localparam logic [15:0] FAST_RW_HI     = 16'hD0AF;
   localparam logic [15:0] FAST_RD_LO     = 16'hD800;
   localparam logic [15:0] FAST_RD_HI     = 16'hDCFF;
   localparam logic [15:0] SERIAL_IO_LO   = 16'hDD00;
   localparam logic [15:0] SERIAL_IO_HI   = 16'hDDFF;
   localparam logic [15:0] TURBO_CFG_ADDR = 16'hD0F3;
   localparam logic [15:0] VIDEO_MODE_ADDR = 16'hD030;
   localparam int          TURBO_EN_BIT   = 7;
   localparam int          MIRROR_BIT     = 5;
   localparam int          AUTO_OFF_BIT   = 4;
   localparam int          LIMIT_LSB      = 0;
   localparam int          VIDEO_TURBO_BIT = 0;
   localparam logic [7:0]  TURBO_CFG_RST  = 8'h00;
   localparam int          SYS_CYCLE_NS   = 1000;
   localparam int          CLK_NS         = 10;
   localparam int          TICKS_PER_CYC  = SYS_CYCLE_NS / CLK_NS;
   localparam int          SLOW_TIME_MS   = 10;
   localparam int          SLOW_CYCLES    = SLOW_TIME_MS * 1000000 / SYS_CYCLE_NS;
   localparam int          WINDOW_CYCLES  = 250;
   localparam logic [3:0]  LIMIT_MAX      = 4'h0;
   localparam logic [3:0]  LIMIT_2X       = 4'h1;
   localparam logic [3:0]  LIMIT_6X       = 4'h5;
   localparam logic [3:0]  SLOW_FIRST     = 4'hC;

   typedef struct packed {
      logic        req;
      logic        we;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } ctsc_bus_t;
endpackage

/* hw/ctsc_top.sv */
// CPU turbo speed controller: grants CPU cycles at a limited or free rate
// Operation
// RULE1: Memory cycles may run fast; every D000-DFFF register access outside the RULE3 ranges runs slow and resynchronised.
// RULE2: An I/O access waits for the start of a system cycle before it begins.
// RULE3: D0A0-D0AF reads and writes and D800-DCFF reads skip the cycle alignment.
// RULE4: Limit code 0001 allows two CPU accesses per system cycle.
// RULE5: Code 0000 grants every free memory slot the other controllers leave.
// RULE6: With auto slowdown on, a serial-bus interface access forces normal speed for 10000 cycles.
// RULE7: Auto slowdown is on by default and bit 4 of the turbo configuration turns it off.
// RULE8: With bit 5 set, bit 0 of the video mode register decides turbo on or off.
// RULE9: Bit 7 of the turbo configuration enables turbo, zero means normal speed.
// RULE10: Speed limit code 0000 is unlimited and 0001 is twice normal speed.
// RULE11: Codes 0010 to 0101 limit to three, four, five and six times normal speed.
// RULE12: The top four codes slow the CPU in 25 percent steps, 1101 giving 75 percent.
// RULE13: The limit caps the average speed over the last 250 CPU cycles; the code caps grants per fixed block of 250 system cycles.
// RULE14: Software should keep auto slowdown enabled so serial peripherals stay reachable.
`timescale 1ns/10ps
module ctsc_top (
   // Clock and reset
   input  wire logic               CLK_SYS,
   input  wire logic               SRST,
   // CPU request
   input  wire ctsc_pkg::ctsc_bus_t CPU_BUS,
   // Memory arbiter: a slot free for the CPU this cycle
   input  wire logic               MEM_SLOT_FREE,
   // Grant and state
   output logic                    CPU_GRANT,
   output logic [7:0]              CFG_RDATA,
   output logic                    TURBO_ACTIVE
);
   ////////////////////////////////////////////////////////////////////////
   function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   logic [7:0]  cfg_q;
   logic        video_turbo_q;
   logic [6:0]  phase_q;
   logic [13:0] slow_cnt_q;
   logic [7:0]  win_cnt_q;
   logic [10:0] win_acc_q;
   logic [3:0]  sub_q;
   logic [3:0]  sub_cur;
   logic        capped;
   logic        wr;
   logic        is_io;
   logic        is_fast_io;
   logic        turbo_on;
   logic        serial_hit;
   logic        cycle_start;
   logic [3:0]  limit;
   logic [10:0] win_budget;
   logic        budget_ok;
   logic        slow_ok;
   logic        grant;

   assign wr    = CPU_BUS.req & CPU_BUS.we;
   assign limit = cfg_q[ctsc_pkg::LIMIT_LSB +: 4];
   assign cycle_start = (phase_q == 7'h00);
   // Count restarts at the cycle edge, so a stale count cannot block the first slot
   assign sub_cur = cycle_start ? 4'h0 : sub_q;
   assign is_io = in_range(CPU_BUS.addr, ctsc_pkg::IO_BASE, ctsc_pkg::IO_LAST); // RULE1
   assign is_fast_io = in_range(CPU_BUS.addr, ctsc_pkg::FAST_RW_LO, ctsc_pkg::FAST_RW_HI)
                     | (~CPU_BUS.we & in_range(CPU_BUS.addr, ctsc_pkg::FAST_RD_LO, ctsc_pkg::FAST_RD_HI)); // RULE3
   assign serial_hit = CPU_BUS.req & in_range(CPU_BUS.addr, ctsc_pkg::SERIAL_IO_LO, ctsc_pkg::SERIAL_IO_HI);

   // Mirror overrides enable bit
   assign turbo_on = (cfg_q[ctsc_pkg::MIRROR_BIT] ? video_turbo_q : cfg_q[ctsc_pkg::TURBO_EN_BIT]) // RULE8 RULE9
                   & (slow_cnt_q == 14'h0000); // RULE6

   ////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         cfg_q <= ctsc_pkg::TURBO_CFG_RST; // RULE7
      end else if (wr && CPU_BUS.addr == ctsc_pkg::TURBO_CFG_ADDR && grant) begin
         cfg_q <= CPU_BUS.wdata;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         video_turbo_q <= 1'b0;
      end else if (wr && CPU_BUS.addr == ctsc_pkg::VIDEO_MODE_ADDR && grant) begin
         video_turbo_q <= CPU_BUS.wdata[ctsc_pkg::VIDEO_TURBO_BIT]; // RULE8
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // System cycle phase and sub-slot pacing
   always_ff @(posedge CLK_SYS) begin
      if (SRST || phase_q == 7'(ctsc_pkg::TICKS_PER_CYC - 1)) begin
         phase_q <= 7'h00;
      end else begin
         phase_q <= phase_q + 7'h01;
      end
   end

   // Grants made in the current system cycle, for the per-cycle cap
   always_ff @(posedge CLK_SYS) begin
      if (SRST || cycle_start) begin
         sub_q <= grant ? 4'h1 : 4'h0;
      end else if (grant) begin
         sub_q <= sub_q + 4'h1;
      end
   end

   // Auto slowdown hold-off
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         slow_cnt_q <= 14'h0000;
      end else if (serial_hit && !cfg_q[ctsc_pkg::AUTO_OFF_BIT]) begin
         slow_cnt_q <= 14'(ctsc_pkg::SLOW_CYCLES); // RULE6 RULE7
      end else if (slow_cnt_q != 14'h0000 && cycle_start) begin
         slow_cnt_q <= slow_cnt_q - 14'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Average window: budget of grants per 250 system cycles
   always_comb begin
      case (limit)
         4'h1:    win_budget = 11'd500;  // RULE4 RULE10
         4'h2:    win_budget = 11'd750;  // RULE11
         4'h3:    win_budget = 11'd1000;
         4'h4:    win_budget = 11'd1250;
         4'h5:    win_budget = 11'd1500;
         4'hC:    win_budget = 11'd250;  // RULE12
         4'hD:    win_budget = 11'd187;
         4'hE:    win_budget = 11'd125;
         4'hF:    win_budget = 11'd62;
         default: win_budget = 11'd2047; // RULE5 RULE10
      endcase
   end

   always_ff @(posedge CLK_SYS) begin
      if (SRST || (cycle_start && win_cnt_q == 8'(ctsc_pkg::WINDOW_CYCLES - 1))) begin
         win_cnt_q <= 8'h00;
         win_acc_q <= 11'h000;
      end else begin
         if (cycle_start) begin
            win_cnt_q <= win_cnt_q + 8'h01;
         end
         // Saturates, so an unlimited stretch cannot wrap the count
         if (grant && win_acc_q != 11'h7FF) begin
            win_acc_q <= win_acc_q + 11'h001;
         end
      end
   end

   // Unlimited and reserved codes skip the window
   assign capped    = (win_budget != 11'h7FF);
   assign budget_ok = !capped | (win_acc_q < win_budget); // RULE13 RULE5
   // Slow modes: at most one grant per system cycle
   assign slow_ok = (limit >= ctsc_pkg::SLOW_FIRST) ? (sub_cur == 4'h0)
                  : (limit == ctsc_pkg::LIMIT_MAX || limit > ctsc_pkg::LIMIT_6X) ? 1'b1
                  : (sub_cur <= limit); // RULE4 RULE11

   always_comb begin
      grant = 1'b0;
      if (CPU_BUS.req) begin
         if (!turbo_on) begin
            grant = cycle_start; // RULE9
         end else if (is_io && !is_fast_io) begin
            grant = cycle_start; // RULE1 RULE2
         end else begin
            grant = MEM_SLOT_FREE & budget_ok & slow_ok; // RULE5 RULE3
         end
      end
   end

   assign CPU_GRANT    = grant;
   assign TURBO_ACTIVE = turbo_on;

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         CFG_RDATA <= 8'h00;
      end else begin
         CFG_RDATA <= cfg_q & 8'hBF;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Serial-bus touch with auto slowdown on, then turbo held off
   sequence s_serial_touch;
      serial_hit && !cfg_q[ctsc_pkg::AUTO_OFF_BIT];
   endsequence
   sequence s_turbo_held_off;
      (!turbo_on) [*8];
   endsequence

   a_io_aligned: assert property (@(posedge CLK_SYS) disable iff (SRST)
      (grant && is_io && !is_fast_io) |-> cycle_start) else $error("slow io granted off cycle start"); // RULE2
   a_normal_aligned: assert property (@(posedge CLK_SYS) disable iff (SRST)
      (grant && !turbo_on) |-> cycle_start) else $error("normal speed grant off cycle start"); // RULE9
   a_slow_hold: assert property (@(posedge CLK_SYS) disable iff (SRST)
      s_serial_touch |=> (slow_cnt_q == 14'(ctsc_pkg::SLOW_CYCLES))) else $error("slowdown not loaded"); // RULE6
   a_slow_turbo_off: assert property (@(posedge CLK_SYS) disable iff (SRST)
      (slow_cnt_q != 14'h0000) |-> !TURBO_ACTIVE) else $error("turbo during slowdown"); // RULE6
   a_auto_disabled: assert property (@(posedge CLK_SYS) disable iff (SRST)
      (serial_hit && cfg_q[ctsc_pkg::AUTO_OFF_BIT] && slow_cnt_q == 14'h0000) |=> (slow_cnt_q == 14'h0000))
      else $error("slowdown despite disable"); // RULE7
   a_mirror_ctrl: assert property (@(posedge CLK_SYS) disable iff (SRST)
      (cfg_q[ctsc_pkg::MIRROR_BIT] && !video_turbo_q) |-> !TURBO_ACTIVE) else $error("mirror off ignored"); // RULE8
   a_twox_cap: assert property (@(posedge CLK_SYS) disable iff (SRST)
      (turbo_on && limit == 4'h1 && !cycle_start && sub_q >= 4'h2) |-> !(grant && MEM_SLOT_FREE && !is_io))
      else $error("2x exceeded"); // RULE4
   a_fast_io: assert property (@(posedge CLK_SYS) disable iff (SRST)
      (CPU_BUS.req && turbo_on && limit == 4'h0 && MEM_SLOT_FREE
       && in_range(CPU_BUS.addr, ctsc_pkg::FAST_RW_LO, ctsc_pkg::FAST_RW_HI)) |-> grant)
      else $error("fast io stalled"); // RULE3
   a_window_cap: assert property (@(posedge CLK_SYS) disable iff (SRST)
      (turbo_on && capped && !is_io && win_acc_q >= win_budget) |-> !grant)
      else $error("window budget exceeded"); // RULE13
   // Longer-lived and mode-wide checks
   a_slow_blocks: assert property (@(posedge CLK_SYS) disable iff (SRST)
      s_serial_touch |=> s_turbo_held_off) else $error("turbo back too soon"); // RULE6
   a_enable_off: assert property (@(posedge CLK_SYS) disable iff (SRST)
      (!cfg_q[ctsc_pkg::MIRROR_BIT] && !cfg_q[ctsc_pkg::TURBO_EN_BIT]) |-> !TURBO_ACTIVE) else $error("turbo while off"); // RULE9
   a_unlimited_grant: assert property (@(posedge CLK_SYS) disable iff (SRST)
      (CPU_BUS.req && turbo_on && limit == ctsc_pkg::LIMIT_MAX && MEM_SLOT_FREE && !is_io) |-> grant)
      else $error("free slot not taken"); // RULE5
   a_slow_one_per: assert property (@(posedge CLK_SYS) disable iff (SRST)
      (limit >= ctsc_pkg::SLOW_FIRST && sub_cur != 4'h0) |-> !grant) else $error("slow mode over one"); // RULE12
endmodule

/* verification/ctsc_arbiter_model.sv */
// Memory arbiter model: offers the CPU a free slot once every period cycles
`timescale 1ns/10ps
module ctsc_arbiter_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       srst,
   // Slot spacing, zero leaves every cycle free
   input  wire logic [3:0] period,
   // Slot offered to the CPU
   output logic            slot_free
);
   logic [3:0] cnt_q;
   always_ff @(posedge clk) begin
      if (srst || cnt_q + 4'h1 >= period) cnt_q <= 4'h0;
      else cnt_q <= cnt_q + 4'h1;
   end
   // Other controllers own the remaining slots
   assign slot_free = (cnt_q == 4'h0);
endmodule

/* verification/ctsc_top_tb.sv */
// Self-checking bench for the CPU turbo speed controller
`timescale 1ns/10ps
module ctsc_top_tb;
   logic                clk_sys = 1'b0;
   logic                srst = 1'b1;
   ctsc_pkg::ctsc_bus_t bus = '0;
   logic [3:0]          slot_period = 4'h0;
   logic                slot_free, grant, turbo;
   logic [7:0]          cfg_rdata;
   int                  n_errors = 0, checks_done = 0, w, t, n;
   logic [15:0]         exp_q[$], seen_q[$];
   string               name_q[$];
   event                res_ev;
   logic [7:0]          rc[8] = '{8'h00, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h8C, 8'h80};
   logic [3:0]          rp[8] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h4};
   logic [15:0]         rx[8] = '{16'd1, 16'd2, 16'd3, 16'd4, 16'd5, 16'd6, 16'd1, 16'd25};
   always #5 clk_sys = ~clk_sys;
   ctsc_top ctsc_top_inst (.CLK_SYS(clk_sys), .SRST(srst), .CPU_BUS(bus), .MEM_SLOT_FREE(slot_free),
      .CPU_GRANT(grant), .CFG_RDATA(cfg_rdata), .TURBO_ACTIVE(turbo));
   ctsc_arbiter_model ctsc_arbiter_model_inst (.clk(clk_sys), .srst(srst), .period(slot_period),
      .slot_free(slot_free));
   task automatic conclude;
      $display("Counts: %0d checks, %0d mismatches", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic check(string nm, logic [15:0] got, logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Compares run in their own process, oldest note first
   always @(res_ev) while (seen_q.size() > 0) check(name_q.pop_front(), seen_q.pop_front(), exp_q.pop_front());
   task automatic report(string nm, logic [15:0] v, logic [15:0] exp);
      exp_q.push_back(exp);
      name_q.push_back(nm);
      seen_q.push_back(v);
      -> res_ev;
   endtask
   // Request held until the grant edge; caller releases
   task automatic access(logic [15:0] a, logic we, logic [7:0] d, output int waited);
      bus <= '{1'b1, we, a, d};
      waited = 0;
      do begin
         @(posedge clk_sys);
         waited++;
         if (waited > 300) begin
            n_errors++;
            conclude();
         end
      end while (grant !== 1'b1);
   endtask
   task automatic wr(logic [15:0] a, logic [7:0] d);
      @(posedge clk_sys);
      access(a, 1'b1, d, w);
      bus.req <= 1'b0;
      repeat (2) @(posedge clk_sys);
   endtask
   initial begin
      void'($urandom(45990));
      repeat (16) @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
      report("cfg after reset", {8'h00, cfg_rdata}, 16'h0000);
      wr(ctsc_pkg::TURBO_CFG_ADDR, 8'hC0);
      report("cfg readback", {8'h00, cfg_rdata}, 16'h0080);
      // Slow I/O lands on phase 0, so spacing is exact
      access(16'hD020, 1'b0, 8'h00, w);
      access(16'hD021, 1'b0, 8'h00, w);
      report("io spacing", 16'(w), 16'd100);
      access(16'hD0A5, 1'b1, 8'h5A, w);
      report("fast rw io", 16'(w), 16'd1);
      access(16'hD800, 1'b0, 8'h00, w);
      report("fast color read", 16'(w), 16'd1);
      access(16'hD800, 1'b1, 8'h01, w);
      report("color write wait", 16'(w), 16'd98);
      bus.req <= 1'b0;
      $display("Test io timing done");
      foreach (rc[i]) begin
         wr(ctsc_pkg::TURBO_CFG_ADDR, rc[i]);
         slot_period <= rp[i];
         t = 0;
         n = 0;
         // Warm up 300 clocks, then count grants over one system cycle
         while (t < 400) begin
            access(16'($urandom_range(16'hCFFF)), 1'($urandom), 8'($urandom), w);
            t += w;
            if (t > 300 && t <= 400) n++;
         end
         bus.req <= 1'b0;
         report("grants per cycle", 16'(n), rx[i]);
      end
      $display("Test speed limits done");
      wr(ctsc_pkg::TURBO_CFG_ADDR, 8'hA0);
      wr(ctsc_pkg::VIDEO_MODE_ADDR, 8'h01);
      report("mirror on", {15'h0000, turbo}, 16'h0001);
      wr(ctsc_pkg::VIDEO_MODE_ADDR, 8'h00);
      report("mirror off", {15'h0000, turbo}, 16'h0000);
      // Slowdown lasts far beyond the run, so it goes last
      wr(ctsc_pkg::TURBO_CFG_ADDR, 8'h90);
      wr(16'hDD00, 8'h00);
      report("auto disabled", {15'h0000, turbo}, 16'h0001);
      wr(ctsc_pkg::TURBO_CFG_ADDR, 8'h80);
      wr(16'hDD0D, 8'h00);
      report("auto slowdown", {15'h0000, turbo}, 16'h0000);
      $display("Test mirror and slowdown done");
      @(posedge clk_sys);
      conclude();
   end
endmodule
